//--- ifp_pkg.sv
package ifp_pkg;

    // Register indices; the bus byte address is index * 4
    localparam logic [7:0] PRIO_HIGH_IDX  = 8'hb9;
    localparam logic [7:0] PRIO_LOW_IDX   = 8'ha9;
    localparam logic [7:0] FLAGS_FOUR_IDX = 8'hc0;
    localparam logic [7:0] FLAGS_FIVE_IDX = 8'he8;
    localparam logic [7:0] REQ_LO_IDX     = 8'hf0;
    localparam logic [7:0] ACTIVE_IDX     = 8'hf1;
    localparam int         ADDR_W         = 10;

    // Flag positions in the fourth flag register
    localparam int SLEEP_TIMER_POS  = 7;
    localparam int PORT_ZERO_POS    = 5;
    localparam int TIMER_FOUR_POS   = 4;
    localparam int TIMER_THREE_POS  = 3;
    localparam int TIMER_TWO_POS    = 2;
    localparam int TIMER_ONE_POS    = 1;
    localparam int TRANSFER_DONE_POS = 0;
    // Flag positions in the fifth flag register
    localparam int WATCHDOG_POS     = 4;
    localparam int PORT_ONE_POS     = 3;
    localparam int SER_ONE_TX_POS   = 2;
    localparam int SER_ZERO_TX_POS  = 1;
    localparam int PORT_TWO_POS     = 0;

    // Reset values and writable masks
    localparam logic [7:0] FLAGS_FOUR_RST  = 8'h00;
    localparam logic [7:0] FLAGS_FIVE_RST  = 8'h00;
    localparam logic [7:0] PRIO_RST        = 8'h00;
    localparam logic [7:0] FLAGS_FOUR_MASK = 8'hbf;
    localparam logic [7:0] FLAGS_FIVE_MASK = 8'h1f;
    localparam logic [7:0] PRIO_MASK       = 8'h3f;

    localparam int NUM_SRC    = 18;
    localparam int NUM_GROUPS = 6;
    localparam int SRC_W      = 5;
    localparam logic [SRC_W-1:0] NO_SRC = 5'h1f;

    // Interrupt number to priority group
    localparam logic [2:0] SRC_GROUP [NUM_SRC] = '{
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
        3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

    // Polling order, earliest first
    localparam logic [SRC_W-1:0] POLL_ORDER [NUM_SRC] = '{
        5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0a, 5'h03, 5'h0b,
        5'h04, 5'h0c, 5'h05, 5'h0d, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11};

    // Interrupt numbers of the sources whose flags live here
    localparam logic [SRC_W-1:0] SRC_TRANSFER_DONE = 5'h08;
    localparam logic [SRC_W-1:0] SRC_TIMER_ONE     = 5'h09;
    localparam logic [SRC_W-1:0] SRC_TIMER_TWO     = 5'h0a;
    localparam logic [SRC_W-1:0] SRC_TIMER_THREE   = 5'h0b;
    localparam logic [SRC_W-1:0] SRC_TIMER_FOUR    = 5'h0c;

    typedef enum logic [2:0] {
        IFP_IDLE = 3'b001,
        IFP_RSP  = 3'b010,
        IFP_DONE = 3'b100
    } ifp_bus_state_t;

endpackage

//--- ifp_arb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ifp_arb_if;
    import ifp_pkg::*;
    logic [NUM_SRC-1:0]    req;
    logic [7:0]            prio_high;
    logic [7:0]            prio_low;
    logic [3:0]            active;
    logic                  win_valid;
    logic [SRC_W-1:0]      win_src;
    logic [1:0]            win_level;
    modport ctrl (output req, output prio_high, output prio_low, output active,
                  input win_valid, input win_src, input win_level);
    modport arb  (input req, input prio_high, input prio_low, input active,
                  output win_valid, output win_src, output win_level);
endinterface
`default_nettype wire

//--- ifp_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_arbiter (
    ifp_arb_if.arb arb
);
    import ifp_pkg::*;

    logic [1:0]       grp_level [NUM_GROUPS];
    logic [1:0]       best_lvl  [NUM_SRC+1];
    logic [SRC_W-1:0] best_src  [NUM_SRC+1];
    logic             best_vld  [NUM_SRC+1];
    logic [3:0]       above;

    function automatic logic [3:0] level_mask(input logic [1:0] lvl);
        level_mask = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (2'(i) > lvl) begin
                level_mask[i] = 1'b1;
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
            assign grp_level[g] = {arb.prio_high[g], arb.prio_low[g]};
        end
    endgenerate

    // Only levels above the highest one in service may nest
    assign above = (arb.active == 4'h0) ? 4'hf :
                   arb.active[3] ? 4'h0 :
                   arb.active[2] ? level_mask(2'h2) :
                   arb.active[1] ? level_mask(2'h1) : level_mask(2'h0);

    assign best_lvl[0] = 2'h0;
    assign best_src[0] = NO_SRC;
    assign best_vld[0] = 1'b0;

    // Walk the polling order; strictly higher level replaces, so ties keep the earlier one
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_poll
            localparam logic [SRC_W-1:0] SRC = POLL_ORDER[g];
            wire [1:0] lvl  = grp_level[SRC_GROUP[SRC]];
            wire       cand = arb.req[SRC] && above[lvl];
            wire       take = cand && (!best_vld[g] || lvl > best_lvl[g]);
            assign best_vld[g+1] = best_vld[g] | cand;
            assign best_lvl[g+1] = take ? lvl : best_lvl[g];
            assign best_src[g+1] = take ? SRC : best_src[g];
        end
    endgenerate

    assign arb.win_valid = best_vld[NUM_SRC];
    assign arb.win_src   = best_src[NUM_SRC];
    assign arb.win_level = best_lvl[NUM_SRC];
endmodule
`default_nettype wire

//--- ifp_bus_slave.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_bus_slave (
    input  wire logic                     sys_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     read_i,
    input  wire logic                     write_i,
    output logic                          waitrequest_o,
    output logic                          rd_take_o,
    output logic                          wr_take_o
);
    import ifp_pkg::*;

    ifp_bus_state_t state_ff;
    ifp_bus_state_t nxt_state;

    // One wait cycle keeps read data a registered value
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IFP_IDLE: begin
                if (read_i || write_i) begin
                    nxt_state = IFP_RSP;
                end
            end
            IFP_RSP:  nxt_state = IFP_DONE;
            IFP_DONE: nxt_state = IFP_IDLE;
            default:  nxt_state = IFP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_ff <= IFP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign waitrequest_o = (read_i || write_i) && (state_ff != IFP_RSP);
    assign rd_take_o     = (state_ff == IFP_IDLE) && read_i;
    assign wr_take_o     = (state_ff == IFP_RSP) && write_i;
endmodule
`default_nettype wire

//--- ifp_top.sv
// Notes on behaviour
// - Sleep timer flag at bit 7 of flags four, reset 0, software read/write.
// - Port 0 flag at bit 5 of flags four; bit 6 unused, reads 0.
// - Timer 4 flag bit 4 set by timer 4, cleared on vectoring.
// - Timer 3 flag bit 3 set by timer 3, cleared on vectoring.
// - Timer 1 flag bit 1 set by timer 1, cleared on vectoring.
// - Timer 2 flag bit 2, cleared in hardware on vectoring.
// - DMA done flag at bit 0 of flags four, reset 0, read/write.
// - Watchdog flag at bit 4 of flags five; bits 7:5 unused.
// - Port 1 flag at bit 3 of flags five, reset 0, read/write.
// - Serial one transmit flag at bit 2 of flags five, reset 0.
// - Serial zero transmit flag at bit 1 of flags five, reset 0.
// - Port 2 flag at bit 0 of flags five, reset 0, read/write.
// - A flag reads 1 when pending, 0 when not.
// - Six priority groups, level from matching bits of both priority registers.
// - Each group takes one of four levels shared by its sources.
// - Service in progress is preempted only by a strictly higher level.
// - Simultaneous same-level requests resolved by fixed polling order.
// - High priority register bits 5:0 per group, reset 0, bits 7:6 unused.
// - Low priority register bits 5:0 per group, reset 0.
// - Group level is high bit over low bit, 3 highest.
// - Group membership of the eighteen sources is fixed.
// - Polling order 0,16,8,1,9,2,10,3,11,4,12,5,13,6,7,14,15,17.
`timescale 1ns/100ps
`default_nettype none
module ifp_top (
    input  wire logic                        sys_clk_i,
    input  wire logic                        nrst_i,
    input  wire logic [ifp_pkg::ADDR_W-1:0]  address_i,
    input  wire logic                        read_i,
    input  wire logic                        write_i,
    input  wire logic [31:0]                 writedata_i,
    input  wire logic [3:0]                  byteenable_i,
    output logic      [31:0]                 readdata_o,
    output logic                             waitrequest_o,
    input  wire logic                        sleep_timer_evt_i,
    input  wire logic                        port_zero_evt_i,
    input  wire logic                        timer_four_evt_i,
    input  wire logic                        timer_three_evt_i,
    input  wire logic                        timer_two_evt_i,
    input  wire logic                        timer_one_evt_i,
    input  wire logic                        transfer_done_evt_i,
    input  wire logic                        watchdog_evt_i,
    input  wire logic                        port_one_evt_i,
    input  wire logic                        serial_one_tx_evt_i,
    input  wire logic                        serial_zero_tx_evt_i,
    input  wire logic                        port_two_evt_i,
    input  wire logic [ifp_pkg::NUM_SRC-1:0] ext_req_i,
    input  wire logic                        int_enable_i,
    output logic                             irq_valid_o,
    output logic      [ifp_pkg::SRC_W-1:0]   irq_src_o,
    output logic      [1:0]                  irq_level_o,
    input  wire logic                        vector_ack_i,
    input  wire logic                        return_i
);
    import ifp_pkg::*;

    ifp_arb_if arb_bus ();

    logic [7:0]  flags_four_ff;
    logic [7:0]  flags_five_ff;
    logic [7:0]  prio_high_ff;
    logic [7:0]  prio_low_ff;
    logic [3:0]  active_ff;
    logic [31:0] readdata_ff;
    logic [7:0]  nxt_flags_four;
    logic [7:0]  nxt_flags_five;
    logic [3:0]  nxt_active;

    logic        rd_take;
    logic        wr_take;
    logic [ADDR_W-1:0] addr_hold_ff;
    wire  [7:0]  reg_idx = addr_hold_ff[ADDR_W-1:2];
    wire         lane0   = byteenable_i[0];
    wire  [7:0]  wdat    = writedata_i[7:0];

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    wire wr_four = wr_take && lane0 && hit(reg_idx, FLAGS_FOUR_IDX);
    wire wr_five = wr_take && lane0 && hit(reg_idx, FLAGS_FIVE_IDX);
    wire wr_high = wr_take && lane0 && hit(reg_idx, PRIO_HIGH_IDX);
    wire wr_low  = wr_take && lane0 && hit(reg_idx, PRIO_LOW_IDX);

    ifp_bus_slave u_slave (
        .sys_clk_i     (sys_clk_i),
        .nrst_i        (nrst_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .waitrequest_o (waitrequest_o),
        .rd_take_o     (rd_take),
        .wr_take_o     (wr_take)
    );

    // Vector taken: which hardware-cleared flag goes away
    wire       vec      = vector_ack_i && irq_valid_o;
    wire [4:0] vec_src  = irq_src_o;
    wire clr_t4  = vec && (vec_src == SRC_TIMER_FOUR);
    wire clr_t3  = vec && (vec_src == SRC_TIMER_THREE);
    wire clr_t2  = vec && (vec_src == SRC_TIMER_TWO);
    wire clr_t1  = vec && (vec_src == SRC_TIMER_ONE);

    // Write first, then hardware clears, then events; an event always wins
    always_comb begin
        nxt_flags_four = flags_four_ff;
        nxt_flags_five = flags_five_ff;
        if (wr_four) begin
            nxt_flags_four = wdat & FLAGS_FOUR_MASK;
        end
        if (wr_five) begin
            nxt_flags_five = wdat & FLAGS_FIVE_MASK;
        end
        if (clr_t4) begin
            nxt_flags_four[TIMER_FOUR_POS] = 1'b0;
        end
        if (clr_t3) begin
            nxt_flags_four[TIMER_THREE_POS] = 1'b0;
        end
        if (clr_t2) begin
            nxt_flags_four[TIMER_TWO_POS] = 1'b0;
        end
        if (clr_t1) begin
            nxt_flags_four[TIMER_ONE_POS] = 1'b0;
        end
        nxt_flags_four[SLEEP_TIMER_POS]   = nxt_flags_four[SLEEP_TIMER_POS]   | sleep_timer_evt_i;
        nxt_flags_four[PORT_ZERO_POS]     = nxt_flags_four[PORT_ZERO_POS]     | port_zero_evt_i;
        nxt_flags_four[TIMER_FOUR_POS]    = nxt_flags_four[TIMER_FOUR_POS]    | timer_four_evt_i;
        nxt_flags_four[TIMER_THREE_POS]   = nxt_flags_four[TIMER_THREE_POS]   | timer_three_evt_i;
        nxt_flags_four[TIMER_TWO_POS]     = nxt_flags_four[TIMER_TWO_POS]     | timer_two_evt_i;
        nxt_flags_four[TIMER_ONE_POS]     = nxt_flags_four[TIMER_ONE_POS]     | timer_one_evt_i;
        nxt_flags_four[TRANSFER_DONE_POS] = nxt_flags_four[TRANSFER_DONE_POS] | transfer_done_evt_i;
        nxt_flags_five[WATCHDOG_POS]      = nxt_flags_five[WATCHDOG_POS]      | watchdog_evt_i;
        nxt_flags_five[PORT_ONE_POS]      = nxt_flags_five[PORT_ONE_POS]      | port_one_evt_i;
        nxt_flags_five[SER_ONE_TX_POS]    = nxt_flags_five[SER_ONE_TX_POS]    | serial_one_tx_evt_i;
        nxt_flags_five[SER_ZERO_TX_POS]   = nxt_flags_five[SER_ZERO_TX_POS]   | serial_zero_tx_evt_i;
        nxt_flags_five[PORT_TWO_POS]      = nxt_flags_five[PORT_TWO_POS]      | port_two_evt_i;
    end

    // In-service levels: set on vectoring, highest dropped on return
    always_comb begin
        nxt_active = active_ff;
        if (return_i) begin
            if (active_ff[3]) begin
                nxt_active[3] = 1'b0;
            end else if (active_ff[2]) begin
                nxt_active[2] = 1'b0;
            end else if (active_ff[1]) begin
                nxt_active[1] = 1'b0;
            end else begin
                nxt_active[0] = 1'b0;
            end
        end
        if (vec) begin
            nxt_active[irq_level_o] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            flags_four_ff <= FLAGS_FOUR_RST;
            flags_five_ff <= FLAGS_FIVE_RST;
            active_ff     <= 4'h0;
        end else begin
            flags_four_ff <= nxt_flags_four;
            flags_five_ff <= nxt_flags_five;
            active_ff     <= nxt_active;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            prio_high_ff <= PRIO_RST;
            prio_low_ff  <= PRIO_RST;
        end else begin
            if (wr_high) begin
                prio_high_ff <= wdat & PRIO_MASK;
            end
            if (wr_low) begin
                prio_low_ff <= wdat & PRIO_MASK;
            end
        end
    end

    // Address held from the first cycle of the access
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            addr_hold_ff <= '0;
        end else if (rd_take || (write_i && !wr_take)) begin
            addr_hold_ff <= address_i;
        end
    end

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_idx = address_i[ADDR_W-1:2];
    wire [7:0] rd_val = hit(rd_idx, FLAGS_FOUR_IDX) ? flags_four_ff :
                        hit(rd_idx, FLAGS_FIVE_IDX) ? flags_five_ff :
                        hit(rd_idx, PRIO_HIGH_IDX)  ? prio_high_ff :
                        hit(rd_idx, PRIO_LOW_IDX)   ? prio_low_ff :
                        hit(rd_idx, ACTIVE_IDX)     ? {4'h0, active_ff} : 8'h00;
    wire [7:0] req_hi = hit(rd_idx, REQ_LO_IDX) ? arb_bus.req[7:0] : 8'h00;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            readdata_ff <= 32'h0000_0000;
        end else if (rd_take) begin
            readdata_ff <= {24'h00_0000, rd_val | req_hi};
        end
    end
    assign readdata_o = readdata_ff;

    // Pending sources: own flags at their interrupt numbers, others from outside
    always_comb begin
        arb_bus.req = ext_req_i & {NUM_SRC{int_enable_i}};
        arb_bus.req[SRC_TRANSFER_DONE] = flags_four_ff[TRANSFER_DONE_POS] && int_enable_i;
        arb_bus.req[SRC_TIMER_ONE]     = flags_four_ff[TIMER_ONE_POS] && int_enable_i;
        arb_bus.req[SRC_TIMER_TWO]     = flags_four_ff[TIMER_TWO_POS] && int_enable_i;
        arb_bus.req[SRC_TIMER_THREE]   = flags_four_ff[TIMER_THREE_POS] && int_enable_i;
        arb_bus.req[SRC_TIMER_FOUR]    = flags_four_ff[TIMER_FOUR_POS] && int_enable_i;
    end
    assign arb_bus.prio_high = prio_high_ff;
    assign arb_bus.prio_low  = prio_low_ff;
    assign arb_bus.active    = active_ff;

    ifp_arbiter u_arb (
        .arb (arb_bus)
    );

    assign irq_valid_o = arb_bus.win_valid;
    assign irq_src_o   = arb_bus.win_src;
    assign irq_level_o = arb_bus.win_level;
endmodule
`default_nettype wire

//--- ifp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_monitor (
    input wire logic                        sys_clk_i,
    input wire logic                        nrst_i,
    input wire logic                        read_i,
    input wire logic                        write_i,
    input wire logic [31:0]                 readdata_o,
    input wire logic                        waitrequest_o,
    input wire logic [ifp_pkg::NUM_SRC-1:0] ext_req_i,
    input wire logic                        int_enable_i,
    input wire logic                        timer_one_evt_i,
    input wire logic                        irq_valid_o,
    input wire logic [ifp_pkg::SRC_W-1:0]   irq_src_o,
    input wire logic [1:0]                  irq_level_o,
    input wire logic                        vector_ack_i,
    input wire logic                        return_i
);
    import ifp_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    bus_wait_a: assert property ((read_i || write_i) && !$past(read_i || write_i) |-> waitrequest_o)
        else $error("request answered in its first cycle");
    bus_answer_a: assert property ((read_i || write_i) |-> ##[0:3] !waitrequest_o)
        else $error("request not answered in time");
    upper_zero_a: assert property (readdata_o[31:8] == 24'h0)
        else $error("read data above the byte lane not zero");
    gate_off_a: assert property (!int_enable_i |-> !irq_valid_o)
        else $error("request offered while disabled");
    idle_src_a: assert property (!irq_valid_o |-> irq_src_o == 5'h1f)
        else $error("source number not idle");
    // Same-cycle event may set the flag again, so it is excluded
    vec_clear_a: assert property (vector_ack_i && irq_valid_o && irq_src_o == SRC_TIMER_ONE && !timer_one_evt_i
        |=> !(irq_valid_o && irq_src_o == SRC_TIMER_ONE)) else $error("timer one flag kept");
    no_preempt_a: assert property (vector_ack_i && irq_valid_o && !return_i
        |=> !irq_valid_o || irq_level_o > $past(irq_level_o)) else $error("equal level nested");
    poll_first_a: assert property (int_enable_i && ext_req_i[0] && irq_valid_o && irq_src_o inside {5'h00, 5'h10, 5'h08}
        |-> irq_src_o == 5'h00) else $error("polling order broken");
endmodule
`default_nettype wire

//--- ifp_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_cpu_model (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       take_i,
    input  wire logic [3:0] lag_i,
    input  wire logic       irq_valid_i,
    output logic            vector_ack_o,
    output logic            taken_o
);
    logic       pend_ff;
    logic [3:0] wait_ff;
    // One vector per take pulse, so a held request is never taken twice
    always_ff @(posedge sys_clk_i) begin
        vector_ack_o <= 1'b0;
        taken_o <= vector_ack_o;
        if (!nrst_i) begin
            pend_ff <= 1'b0;
            wait_ff <= 4'h0;
        end else if (take_i) begin
            pend_ff <= 1'b1;
            wait_ff <= 4'h0;
        end else if (pend_ff && irq_valid_i) begin
            if (wait_ff == lag_i) begin
                vector_ack_o <= 1'b1;
                pend_ff <= 1'b0;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- ifp_testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ifp_pkg::*;
    logic        sys_clk_i;
    logic        nrst_i;
    logic [9:0]  address_i;
    logic        read_i;
    logic        write_i;
    logic [31:0] writedata_i;
    logic [3:0]  byteenable_i;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic [11:0] evt;
    logic [17:0] ext_req_i;
    logic        int_enable_i;
    logic        irq_valid_o;
    logic [4:0]  irq_src_o;
    logic [1:0]  irq_level_o;
    logic        vector_ack;
    logic        return_i;
    logic        take;
    logic        taken;
    logic [3:0]  lag;
    logic [7:0]  q;
    logic [7:0]  idx [5];
    logic [7:0]  msk [5];
    logic [4:0]  xs [4];
    logic [1:0]  xl [4];
    int          bad_count;
    int          n_checks;

    ifp_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .transfer_done_evt_i(evt[0]), .timer_one_evt_i(evt[1]),
        .timer_two_evt_i(evt[2]), .timer_three_evt_i(evt[3]), .timer_four_evt_i(evt[4]),
        .port_zero_evt_i(evt[5]), .sleep_timer_evt_i(evt[6]), .port_two_evt_i(evt[7]),
        .serial_zero_tx_evt_i(evt[8]), .serial_one_tx_evt_i(evt[9]), .port_one_evt_i(evt[10]),
        .watchdog_evt_i(evt[11]), .ext_req_i(ext_req_i), .int_enable_i(int_enable_i),
        .irq_valid_o(irq_valid_o), .irq_src_o(irq_src_o), .irq_level_o(irq_level_o),
        .vector_ack_i(vector_ack), .return_i(return_i));

    ifp_cpu_model i_cpu (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .take_i(take), .lag_i(lag),
        .irq_valid_i(irq_valid_o), .vector_ack_o(vector_ack), .taken_o(taken));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Level is only meaningful while a request is offered
    task automatic chk_irq(input logic v, input logic [4:0] s, input logic [1:0] l);
        logic [7:0] got;
        @(negedge sys_clk_i);
        got = {irq_valid_o, irq_src_o, v ? irq_level_o : 2'h0};
        @(posedge sys_clk_i);
        chk_reg(got, {v, s, l});
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n = 0;
        address_i <= {a, 2'b00};
        writedata_i <= {24'h0, d};
        byteenable_i <= 4'h1;
        write_i <= w;
        read_i <= !w;
        @(posedge sys_clk_i);
        // Request stands until the edge that sees waitrequest low; data taken there
        while (waitrequest_o !== 1'b0 && n < 20) begin
            n++;
            @(posedge sys_clk_i);
        end
        r = readdata_o[7:0];
        write_i <= 1'b0;
        read_i <= 1'b0;
        @(posedge sys_clk_i);
        if (n == 20) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic fire(input logic [11:0] m);
        evt <= m;
        @(posedge sys_clk_i);
        evt <= 12'h000;
        @(posedge sys_clk_i);
    endtask

    task automatic vec();
        int n = 0;
        take <= 1'b1;
        @(posedge sys_clk_i);
        take <= 1'b0;
        while (taken !== 1'b1 && n < 40) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic ret();
        return_i <= 1'b1;
        @(posedge sys_clk_i);
        return_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    initial begin
        {nrst_i, address_i, read_i, write_i, writedata_i, byteenable_i} = '0;
        {evt, ext_req_i, int_enable_i, return_i, take, lag} = '0;
        bad_count = 0;
        n_checks = 0;
        idx = '{FLAGS_FOUR_IDX, FLAGS_FIVE_IDX, PRIO_HIGH_IDX, PRIO_LOW_IDX, 8'h10};
        msk = '{8'hbf, 8'h1f, 8'h3f, 8'h3f, 8'h00};
        xs = '{5'h0c, 5'h09, 5'h0b, 5'h0a};
        xl = '{2'h3, 2'h2, 2'h1, 2'h0};
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        // Last entry is an unmapped place: reads 0, writes lost
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, idx[i], 8'h00, q);
            chk_reg(q, 8'h00);
            bus(1'b1, idx[i], 8'hff, q);
            bus(1'b0, idx[i], 8'h00, q);
            chk_reg(q, msk[i]);
            bus(1'b1, idx[i], 8'h00, q);
        end
        $display("registers done");
        for (int i = 0; i < 12; i++) begin
            fire(12'h001 << i);
            bus(1'b0, i < 7 ? FLAGS_FOUR_IDX : FLAGS_FIVE_IDX, 8'h00, q);
            chk_reg(q, i == 6 ? 8'h80 : 8'h01 << (i < 7 ? i : i - 7));
            bus(1'b1, i < 7 ? FLAGS_FOUR_IDX : FLAGS_FIVE_IDX, 8'h00, q);
        end
        $display("events done");
        int_enable_i <= 1'b1;
        fire(12'h01f);
        chk_irq(1'b1, 5'h08, 2'h0);
        vec();
        chk_irq(1'b0, 5'h1f, 2'h0);
        ret();
        bus(1'b1, FLAGS_FOUR_IDX, 8'h1e, q);
        for (int k = 1; k < 5; k++) begin
            chk_irq(1'b1, 5'(8 + k), 2'h0);
            vec();
            bus(1'b0, ACTIVE_IDX, 8'h00, q);
            chk_reg(q, 8'h01);
            bus(1'b0, FLAGS_FOUR_IDX, 8'h00, q);
            chk_reg(q, 8'h1e & (8'h1e << k));
            ret();
        end
        chk_irq(1'b0, 5'h1f, 2'h0);
        $display("vectoring done");
        bus(1'b1, PRIO_HIGH_IDX, 8'h12, q);
        bus(1'b1, PRIO_LOW_IDX, 8'h18, q);
        lag <= 4'h3;
        fire(12'h01e);
        for (int k = 0; k < 4; k++) begin
            chk_irq(1'b1, xs[k], xl[k]);
            vec();
            ret();
        end
        lag <= 4'h0;
        fire(12'h004);
        vec();
        fire(12'h010);
        chk_irq(1'b1, 5'h0c, 2'h3);
        vec();
        fire(12'h008);
        chk_irq(1'b0, 5'h1f, 2'h0);
        ret();
        chk_irq(1'b1, 5'h0b, 2'h1);
        vec();
        ret();
        ret();
        ext_req_i <= 18'h10001;
        chk_irq(1'b1, 5'h00, 2'h0);
        bus(1'b0, REQ_LO_IDX, 8'h00, q);
        chk_reg(q, 8'h01);
        vec();
        ext_req_i <= 18'h10000;
        chk_irq(1'b0, 5'h1f, 2'h0);
        ret();
        chk_irq(1'b1, 5'h10, 2'h0);
        ext_req_i <= 18'h00000;
        $display("priority done");
        wrap_up();
    end
endmodule

bind ifp_top ifp_monitor i_mon (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .read_i(read_i), .write_i(write_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .ext_req_i(ext_req_i), .int_enable_i(int_enable_i),
    .timer_one_evt_i(timer_one_evt_i), .irq_valid_o(irq_valid_o), .irq_src_o(irq_src_o),
    .irq_level_o(irq_level_o), .vector_ack_i(vector_ack_i), .return_i(return_i));
`default_nettype wire
